// ===== operand_addressing_decoder.sv
// Purpose: instruction length and operand address generation for all addressing modes
// Assumes: memory answers each held read with MEM_RD_VALID; INSN_PC is the first byte
//          of the instruction (the prefix byte when the second index is used)
// Notes:   one instruction in flight; START is ignored while busy
module operand_addressing_decoder
    import opdec_pkg::*;
(
    input  wire logic            REF_CLK,
    input  wire logic            RESETN,
    input  wire logic            START,
    input  wire addr_mode_type   MODE,
    input  wire insn_group_type  GROUP,
    input  wire inherent_op_type INHERENT_OP,
    input  wire logic            USE_SECOND_INDEX,
    input  wire logic [7:0]      INDEX_FIRST,
    input  wire logic [7:0]      INDEX_SECOND,
    input  wire logic [15:0]     INSN_PC,
    output logic                 MEM_RD_REQ,
    output logic      [15:0]     MEM_ADDR,
    input  wire logic [7:0]      MEM_RD_DATA,
    input  wire logic            MEM_RD_VALID,
    output logic                 BUSY,
    output logic                 DONE,
    output logic                 ILLEGAL,
    output logic      [2:0]      INSN_LENGTH,
    output logic      [15:0]     OPERAND_ADDR,
    output logic      [7:0]      OPERAND_VALUE,
    output logic                 OPERAND_IS_VALUE,
    output logic                 BRANCH,
    output logic      [15:0]     BRANCH_TARGET,
    output inherent_op_type      INHERENT_KIND
);

    typedef enum logic [2:0] {
        st_idle,
        st_arg1,
        st_arg2,
        st_ptr1,
        st_ptr2,
        st_finish
    } state_type;

    // =====================================================================
    // state and latched request
    state_type       state_r, state_nxt;
    addr_mode_type   mode_r;
    inherent_op_type inh_r;
    logic            second_r;
    logic [7:0]      idx_r;
    logic [15:0]     pc_r;
    logic [7:0]      arg1_r, arg2_r, ptr1_r, ptr2_r;
    logic [15:0]     mem_addr_r, mem_addr_nxt;

    // output registers
    logic            done_r, illegal_r, is_value_r, branch_r;
    logic [2:0]      len_r;
    logic [15:0]     ea_r, target_r;
    logic [7:0]      value_r;
    inherent_op_type kind_r;

    // =====================================================================
    // request checks
    wire logic idle      = (state_r == st_idle);
    wire logic take      = idle && START;
    wire logic grp_ok_inh = (GROUP == grp_inherent) && (MODE == am_inherent);
    wire logic grp_ok_lng = (GROUP == grp_long_ok) && !is_relative(MODE) &&
                            (MODE != am_inherent);
    wire logic grp_ok_sht = (GROUP == grp_short_only) && !is_long(MODE) &&
                            !is_relative(MODE) && (MODE != am_immediate);
    wire logic grp_ok_rel = (GROUP == grp_relative) && is_relative(MODE);
    wire logic allowed   = grp_ok_inh || grp_ok_lng || grp_ok_sht || grp_ok_rel;
    wire logic [1:0] in_bytes = operand_bytes(MODE);
    wire logic in_second = USE_SECOND_INDEX && uses_index(MODE);
    wire logic [15:0] first_arg = INSN_PC + {13'h0000, LEN_OPCODE} +
                                  {15'h0000, in_second};

    // =====================================================================
    // sequencing
    wire logic got        = MEM_RD_VALID;
    wire logic need_word  = (mode_r == am_ind_long) || (mode_r == am_indidx_long);
    wire logic [15:0] ptr_addr = {PAGE_ZERO_HI, MEM_RD_DATA};

    always_comb begin
        state_nxt    = state_r;
        mem_addr_nxt = mem_addr_r;
        unique case (state_r)
            st_idle: begin
                if (take && allowed) begin
                    mem_addr_nxt = first_arg;
                    state_nxt    = (in_bytes == 2'd0) ? st_finish : st_arg1;
                end
            end
            st_arg1: begin
                if (got) begin
                    if (operand_bytes(mode_r) == 2'd2) begin
                        mem_addr_nxt = mem_addr_r + NEXT_BYTE;
                        state_nxt    = st_arg2;
                    end else if (uses_pointer(mode_r)) begin
                        mem_addr_nxt = ptr_addr;
                        state_nxt    = st_ptr1;
                    end else begin
                        state_nxt    = st_finish;
                    end
                end
            end
            st_arg2: begin
                if (got) begin
                    state_nxt = st_finish;
                end
            end
            st_ptr1: begin
                if (got) begin
                    mem_addr_nxt = mem_addr_r + NEXT_BYTE;
                    state_nxt    = need_word ? st_ptr2 : st_finish;
                end
            end
            st_ptr2: begin
                if (got) begin
                    state_nxt = st_finish;
                end
            end
            st_finish: begin
                state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r    <= st_idle;
            mem_addr_r <= ADDR_RESET;
        end else begin
            state_r    <= state_nxt;
            mem_addr_r <= mem_addr_nxt;
        end
    end

    // latch the request when taken
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_r   <= am_inherent;
            inh_r    <= nop_op;
            second_r <= 1'b0;
            idx_r    <= BYTE_RESET;
            pc_r     <= ADDR_RESET;
        end else if (take) begin
            mode_r   <= MODE;
            inh_r    <= INHERENT_OP;
            second_r <= in_second;
            idx_r    <= in_second ? INDEX_SECOND : INDEX_FIRST;
            pc_r     <= INSN_PC;
        end
    end

    // fetched bytes
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            arg1_r <= BYTE_RESET;
            arg2_r <= BYTE_RESET;
            ptr1_r <= BYTE_RESET;
            ptr2_r <= BYTE_RESET;
        end else if (got) begin
            if (state_r == st_arg1) arg1_r <= MEM_RD_DATA;
            if (state_r == st_arg2) arg2_r <= MEM_RD_DATA;
            if (state_r == st_ptr1) ptr1_r <= MEM_RD_DATA;
            if (state_r == st_ptr2) ptr2_r <= MEM_RD_DATA;
        end
    end

    // =====================================================================
    // address arithmetic
    wire logic [15:0] arg_word = {arg1_r, arg2_r};
    wire logic [15:0] ptr_word = {ptr1_r, ptr2_r};
    wire logic        idx_short_form = (mode_r == am_idx_short) ||
                                       (mode_r == am_indidx_short);
    logic [15:0] idx_base;
    logic [15:0] idx_sum;
    logic [15:0] ea;

    always_comb begin
        unique case (mode_r)
            am_idx_short:    idx_base = {PAGE_ZERO_HI, arg1_r};
            am_idx_long:     idx_base = arg_word;
            am_indidx_short: idx_base = {PAGE_ZERO_HI, ptr1_r};
            am_indidx_long:  idx_base = ptr_word;
            default:         idx_base = ADDR_RESET;
        endcase
    end

    index_adder u_index_adder (
        .base       (idx_base),
        .index      (idx_r),
        .short_form (idx_short_form),
        .sum        (idx_sum)
    );

    always_comb begin
        unique case (mode_r)
            am_dir_short:    ea = {PAGE_ZERO_HI, arg1_r};
            am_dir_long:     ea = arg_word;
            am_idx_none:     ea = {PAGE_ZERO_HI, idx_r};
            am_ind_short:    ea = {PAGE_ZERO_HI, ptr1_r};
            am_ind_long:     ea = ptr_word;
            am_idx_short, am_idx_long, am_indidx_short, am_indidx_long:
                             ea = idx_sum;
            default:         ea = ADDR_RESET;
        endcase
    end

    wire logic [2:0]  length   = LEN_OPCODE + {1'b0, operand_bytes(mode_r)} +
                                 (second_r ? LEN_PREFIX : LEN_RESET);
    wire logic [15:0] next_pc  = pc_r + {13'h0000, length};
    wire logic [7:0]  rel_off  = (mode_r == am_rel_direct) ? arg1_r : ptr1_r;
    wire logic [15:0] rel_tgt  = next_pc + {{8{rel_off[7]}}, rel_off};
    wire logic        finish   = (state_r == st_finish);

    // =====================================================================
    // results
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            done_r    <= finish;
            illegal_r <= take && !allowed;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            len_r      <= LEN_RESET;
            ea_r       <= ADDR_RESET;
            value_r    <= BYTE_RESET;
            is_value_r <= 1'b0;
            branch_r   <= 1'b0;
            target_r   <= ADDR_RESET;
            kind_r     <= nop_op;
        end else if (finish) begin
            len_r      <= length;
            ea_r       <= ea;
            value_r    <= (mode_r == am_immediate) ? arg1_r : BYTE_RESET;
            is_value_r <= (mode_r == am_immediate);
            branch_r   <= is_relative(mode_r);
            target_r   <= is_relative(mode_r) ? rel_tgt : next_pc;
            kind_r     <= (mode_r == am_inherent) ? inh_r : register_data_op;
        end
    end

    assign MEM_RD_REQ       = (state_r == st_arg1) || (state_r == st_arg2) ||
                              (state_r == st_ptr1) || (state_r == st_ptr2);
    assign MEM_ADDR         = mem_addr_r;
    assign BUSY             = !idle;
    assign DONE             = done_r;
    assign ILLEGAL          = illegal_r;
    assign INSN_LENGTH      = len_r;
    assign OPERAND_ADDR     = ea_r;
    assign OPERAND_VALUE    = value_r;
    assign OPERAND_IS_VALUE = is_value_r;
    assign BRANCH           = branch_r;
    assign BRANCH_TARGET    = target_r;
    assign INHERENT_KIND    = kind_r;

    // =====================================================================
    // checks
    chk_inherent_one_byte: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        take && allowed && MODE == am_inherent |-> !MEM_RD_REQ ##2 DONE && INSN_LENGTH == 3'h1)
        else $error("inherent instruction not one byte");

    chk_immediate_value: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && mode_r == am_immediate |=> OPERAND_IS_VALUE && OPERAND_VALUE == arg1_r
            && INSN_LENGTH == 3'h2)
        else $error("immediate operand wrong");

    chk_short_direct_page: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && mode_r == am_dir_short |=> OPERAND_ADDR == {8'h00, $past(arg1_r)})
        else $error("short direct address wrong");

    chk_long_direct_word: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && mode_r == am_dir_long |=> OPERAND_ADDR == {$past(arg1_r), $past(arg2_r)})
        else $error("long direct address wrong");

    chk_noofs_index_addr: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && mode_r == am_idx_none |=> OPERAND_ADDR == {8'h00, $past(idx_r)})
        else $error("no-offset indexed address wrong");

    chk_short_index_span: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && idx_short_form |=> OPERAND_ADDR[15:9] == 7'h00 &&
            OPERAND_ADDR[8:0] == {1'b0, $past(idx_base[7:0])} + {1'b0, $past(idx_r)})
        else $error("short indexed sum wrong");

    chk_prefix_length: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && second_r |=> INSN_LENGTH == $past({1'b0, operand_bytes(mode_r)}) + 3'h2)
        else $error("prefix byte not counted");

    chk_short_only_long: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        take && GROUP == grp_short_only && is_long(MODE) |=> ILLEGAL && state_r == st_idle)
        else $error("long form accepted in short-only group");

    chk_pointer_fetch: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        state_r == st_arg1 && got && uses_pointer(mode_r) |=>
            state_r == st_ptr1 && MEM_ADDR == {8'h00, $past(MEM_RD_DATA)})
        else $error("pointer fetched from wrong address");

    chk_relative_target: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        finish && is_relative(mode_r) |=> BRANCH &&
            BRANCH_TARGET == $past(next_pc) + {{8{$past(rel_off[7])}}, $past(rel_off)})
        else $error("relative target wrong");

endmodule : operand_addressing_decoder

// ===== opdec_pkg.sv
// Purpose: shared types, constants and mode helpers for the operand addressing decoder
// Assumes: 8-bit data, 16-bit address space, pointer words stored high byte first
// Notes:   no registers reachable by software
package opdec_pkg;

    // =====================================================================
    // widths and reset values
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 8;
    localparam logic [15:0] ADDR_RESET   = 16'h0000;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
    localparam logic [15:0] NEXT_BYTE    = 16'h0001;
    localparam logic [2:0]  LEN_OPCODE   = 3'h1;
    localparam logic [2:0]  LEN_PREFIX   = 3'h1;
    localparam logic [2:0]  LEN_RESET    = 3'h0;

    // =====================================================================
    // enumerations
    typedef enum logic [3:0] {
        am_inherent,
        am_immediate,
        am_dir_short,
        am_dir_long,
        am_idx_none,
        am_idx_short,
        am_idx_long,
        am_ind_short,
        am_ind_long,
        am_indidx_short,
        am_indidx_long,
        am_rel_direct,
        am_rel_indirect
    } addr_mode_type;

    typedef enum logic [1:0] {
        grp_inherent,
        grp_long_ok,
        grp_short_only,
        grp_relative
    } insn_group_type;

    typedef enum logic [3:0] {
        nop_op,
        trap_op,
        wait_interrupt_op,
        halt_op,
        subroutine_return_op,
        interrupt_return_op,
        mask_set_op,
        mask_clear_op,
        carry_set_op,
        carry_clear_op,
        stack_pointer_reset_op,
        register_data_op
    } inherent_op_type;

    // =====================================================================
    // mode helpers
    function automatic logic [1:0] operand_bytes(input addr_mode_type m);
        unique case (m)
            am_inherent, am_idx_none:  operand_bytes = 2'd0;
            am_dir_long, am_idx_long:  operand_bytes = 2'd2;
            default:                   operand_bytes = 2'd1;
        endcase
    endfunction : operand_bytes

    function automatic logic is_long(input addr_mode_type m);
        is_long = (m == am_dir_long) || (m == am_idx_long) ||
                  (m == am_ind_long) || (m == am_indidx_long);
    endfunction : is_long

    function automatic logic is_relative(input addr_mode_type m);
        is_relative = (m == am_rel_direct) || (m == am_rel_indirect);
    endfunction : is_relative

    function automatic logic uses_pointer(input addr_mode_type m);
        uses_pointer = (m == am_ind_short) || (m == am_ind_long) ||
                       (m == am_indidx_short) || (m == am_indidx_long) ||
                       (m == am_rel_indirect);
    endfunction : uses_pointer

    function automatic logic uses_index(input addr_mode_type m);
        uses_index = (m == am_idx_none) || (m == am_idx_short) || (m == am_idx_long) ||
                     (m == am_indidx_short) || (m == am_indidx_long);
    endfunction : uses_index

endpackage : opdec_pkg

// ===== index_adder.sv
// Purpose: unsigned index addition for indexed and indirect indexed forms
// Assumes: short forms add to a byte base, long forms to a word base
// Notes:   purely combinational
module index_adder
    import opdec_pkg::*;
(
    input  wire logic [15:0] base,
    input  wire logic [7:0]  index,
    input  wire logic        short_form,
    output logic      [15:0] sum
);

    // =====================================================================
    // adders
    wire logic [8:0]  short_sum = {1'b0, base[7:0]} + {1'b0, index};
    wire logic [15:0] long_sum  = base + {PAGE_ZERO_HI, index};

    // carry out of bit 7 kept as bit 8, upper bits zero
    assign sum = short_form ? {7'h00, short_sum} : long_sum;

endmodule : index_adder

// ===== opdec_mem_model.sv
// Purpose: behavioural program and data memory facing the operand decoder
// Assumes: one byte answered per held request, registered answer
// Notes:   wait_cycles stretches every answer; data toggles when nothing is read
module opdec_mem_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rd_req,
    input  wire logic [15:0] addr,
    input  wire logic [1:0]  wait_cycles,
    output logic      [7:0]  rd_data,
    output logic             rd_valid
);
    // =====================================================================
    // storage and answer timing
    logic [7:0] mem [0:65535];
    logic [1:0] cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r    <= 2'h0;
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_valid <= 1'b0;
            // stale data is never left standing on the bus
            rd_data  <= ~rd_data;
            if (rd_req && !rd_valid) begin
                if (cnt_r == wait_cycles) begin
                    rd_valid <= 1'b1;
                    rd_data  <= mem[addr];
                    cnt_r    <= 2'h0;
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    end
endmodule : opdec_mem_model

// ===== operand_addressing_decoder_tb.sv
// Purpose: self-checking bench for the operand addressing decoder
// Assumes: memory model answers reads, words stored high byte first
// Notes:   one task per scenario, each judged before it returns
module operand_addressing_decoder_tb
    import opdec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // signals
    logic            ref_clk = 1'b0;
    logic            resetn  = 1'b0;
    logic            start   = 1'b0;
    logic            use_sec = 1'b0;
    addr_mode_type   mode    = am_inherent;
    insn_group_type  grp     = grp_inherent;
    inherent_op_type iop     = nop_op;
    inherent_op_type kind;
    logic [7:0]      idx1    = 8'hff;
    logic [7:0]      idx2    = 8'h42;
    logic [15:0]     pc      = 16'h0000;
    logic [1:0]      mem_wait = 2'h0;
    logic            rd_req, rd_valid, busy, done, illegal, is_val, branch;
    logic [7:0]      rd_data, op_val;
    logic [15:0]     mem_addr, op_addr, tgt;
    logic [2:0]      len;
    int              mismatches = 0;
    int              cmp_count  = 0;
    int              n_reads;

    always #50 ref_clk = ~ref_clk;

    operand_addressing_decoder u_operand_addressing_decoder (
        .REF_CLK(ref_clk), .RESETN(resetn), .START(start), .MODE(mode), .GROUP(grp),
        .INHERENT_OP(iop), .USE_SECOND_INDEX(use_sec), .INDEX_FIRST(idx1),
        .INDEX_SECOND(idx2), .INSN_PC(pc), .MEM_RD_REQ(rd_req), .MEM_ADDR(mem_addr),
        .MEM_RD_DATA(rd_data), .MEM_RD_VALID(rd_valid), .BUSY(busy), .DONE(done),
        .ILLEGAL(illegal), .INSN_LENGTH(len), .OPERAND_ADDR(op_addr),
        .OPERAND_VALUE(op_val), .OPERAND_IS_VALUE(is_val), .BRANCH(branch),
        .BRANCH_TARGET(tgt), .INHERENT_KIND(kind));

    opdec_mem_model u_opdec_mem_model (
        .clk(ref_clk), .rstn(resetn), .rd_req(rd_req), .addr(mem_addr),
        .wait_cycles(mem_wait), .rd_data(rd_data), .rd_valid(rd_valid));

    // =====================================================================
    // reporting and comparison
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_val({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_flag

    // one decode request, waits for done or illegal and counts reads taken
    task automatic run(input addr_mode_type m, input insn_group_type g,
                       input inherent_op_type o, input logic sec, input logic [15:0] p);
        int i;
        @(posedge ref_clk);
        mode    <= m;
        grp     <= g;
        iop     <= o;
        use_sec <= sec;
        pc      <= p;
        start   <= 1'b1;
        @(posedge ref_clk);
        start   <= 1'b0;
        n_reads = 0;
        // illegal stands only in the cycle right after the taking edge
        for (i = 0; i < 60; i++) begin
            #1;
            if (rd_req === 1'b1 && rd_valid === 1'b1) n_reads++;
            if (done === 1'b1 || illegal === 1'b1) break;
            @(posedge ref_clk);
        end
        if (i == 60) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            stop_test;
        end
    endtask : run

    task automatic expect_res(input logic ill, input logic [2:0] l, input logic [15:0] a,
                              input logic [15:0] reads);
        cmp_flag(illegal, ill);
        cmp_val({13'h0000, len}, {13'h0000, l});
        cmp_val(op_addr, a);
        cmp_val(n_reads[15:0], reads);
    endtask : expect_res

    // =====================================================================
    // scenarios
    task automatic test_inherent;
        for (int j = 1; j <= 10; j++) begin
            run(am_inherent, grp_inherent, inherent_op_type'(j), 1'b0, 16'h0200);
            expect_res(1'b0, 3'h1, 16'h0000, 16'h0000);
            cmp_val({12'h000, kind}, j[15:0]);
        end
        $display("test_inherent done");
    endtask : test_inherent

    task automatic test_imm_direct;
        u_opdec_mem_model.mem[16'h0301] = 8'hc3;
        run(am_immediate, grp_long_ok, nop_op, 1'b0, 16'h0300);
        expect_res(1'b0, 3'h2, 16'h0000, 16'h0001);
        cmp_val({8'h00, op_val}, 16'h00c3);
        cmp_flag(is_val, 1'b1);
        u_opdec_mem_model.mem[16'h0401] = 8'h9e;
        run(am_dir_short, grp_short_only, nop_op, 1'b0, 16'h0400);
        expect_res(1'b0, 3'h2, 16'h009e, 16'h0001);
        cmp_flag(is_val, 1'b0);
        cmp_flag(branch, 1'b0);
        cmp_val({12'h000, kind}, {12'h000, register_data_op});
        mem_wait = 2'h2;
        u_opdec_mem_model.mem[16'h0501] = 8'hab;
        u_opdec_mem_model.mem[16'h0502] = 8'hcd;
        run(am_dir_long, grp_long_ok, nop_op, 1'b0, 16'h0500);
        expect_res(1'b0, 3'h3, 16'habcd, 16'h0002);
        mem_wait = 2'h0;
        $display("test_imm_direct done");
    endtask : test_imm_direct

    task automatic test_indexed;
        run(am_idx_none, grp_long_ok, nop_op, 1'b0, 16'h0600);
        expect_res(1'b0, 3'h1, 16'h00ff, 16'h0000);
        run(am_idx_none, grp_short_only, nop_op, 1'b1, 16'h0600);
        expect_res(1'b0, 3'h2, 16'h0042, 16'h0000);
        u_opdec_mem_model.mem[16'h0701] = 8'hff;
        run(am_idx_short, grp_short_only, nop_op, 1'b0, 16'h0700);
        expect_res(1'b0, 3'h2, 16'h01fe, 16'h0001);
        u_opdec_mem_model.mem[16'h0802] = 8'h10;
        run(am_idx_short, grp_long_ok, nop_op, 1'b1, 16'h0800);
        expect_res(1'b0, 3'h3, 16'h0052, 16'h0001);
        u_opdec_mem_model.mem[16'h0901] = 8'hff;
        u_opdec_mem_model.mem[16'h0902] = 8'h80;
        run(am_idx_long, grp_long_ok, nop_op, 1'b0, 16'h0900);
        expect_res(1'b0, 3'h3, 16'h007f, 16'h0002);
        $display("test_indexed done");
    endtask : test_indexed

    task automatic test_indirect;
        u_opdec_mem_model.mem[16'h0a01] = 8'h20;
        u_opdec_mem_model.mem[16'h0020] = 8'h77;
        run(am_ind_short, grp_short_only, nop_op, 1'b0, 16'h0a00);
        expect_res(1'b0, 3'h2, 16'h0077, 16'h0002);
        u_opdec_mem_model.mem[16'h0b01] = 8'hff;
        u_opdec_mem_model.mem[16'h00ff] = 8'h12;
        u_opdec_mem_model.mem[16'h0100] = 8'h34;
        run(am_ind_long, grp_long_ok, nop_op, 1'b0, 16'h0b00);
        expect_res(1'b0, 3'h2, 16'h1234, 16'h0003);
        u_opdec_mem_model.mem[16'h0c01] = 8'h30;
        u_opdec_mem_model.mem[16'h0030] = 8'h81;
        run(am_indidx_short, grp_short_only, nop_op, 1'b0, 16'h0c00);
        expect_res(1'b0, 3'h2, 16'h0180, 16'h0002);
        u_opdec_mem_model.mem[16'h0d01] = 8'h40;
        u_opdec_mem_model.mem[16'h0040] = 8'h20;
        u_opdec_mem_model.mem[16'h0041] = 8'hf0;
        run(am_indidx_long, grp_long_ok, nop_op, 1'b0, 16'h0d00);
        expect_res(1'b0, 3'h2, 16'h21ef, 16'h0003);
        $display("test_indirect done");
    endtask : test_indirect

    task automatic test_groups;
        addr_mode_type long_modes [4] = '{am_dir_long, am_idx_long, am_ind_long, am_indidx_long};
        for (int j = 0; j < 4; j++) begin
            run(long_modes[j], grp_short_only, nop_op, 1'b0, 16'h0e00);
            expect_res(1'b1, 3'h2, 16'h21ef, 16'h0000);
        end
        run(am_rel_direct, grp_long_ok, nop_op, 1'b0, 16'h0e00);
        expect_res(1'b1, 3'h2, 16'h21ef, 16'h0000);
        run(am_immediate, grp_short_only, nop_op, 1'b0, 16'h0e00);
        expect_res(1'b1, 3'h2, 16'h21ef, 16'h0000);
        run(am_dir_short, grp_relative, nop_op, 1'b0, 16'h0e00);
        expect_res(1'b1, 3'h2, 16'h21ef, 16'h0000);
        $display("test_groups done");
    endtask : test_groups

    task automatic test_relative;
        u_opdec_mem_model.mem[16'h1001] = 8'h80;
        run(am_rel_direct, grp_relative, nop_op, 1'b0, 16'h1000);
        expect_res(1'b0, 3'h2, 16'h0000, 16'h0001);
        cmp_flag(branch, 1'b1);
        cmp_val(tgt, 16'h0f82);
        mem_wait = 2'h3;
        u_opdec_mem_model.mem[16'h1101] = 8'h50;
        u_opdec_mem_model.mem[16'h0050] = 8'h7f;
        run(am_rel_indirect, grp_relative, nop_op, 1'b0, 16'h1100);
        expect_res(1'b0, 3'h2, 16'h0000, 16'h0002);
        cmp_val(tgt, 16'h1181);
        mem_wait = 2'h0;
        $display("test_relative done");
    endtask : test_relative

    // =====================================================================
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        cmp_flag(busy, 1'b0);
        cmp_val(op_addr, 16'h0000);
        test_inherent;
        test_imm_direct;
        test_indexed;
        test_indirect;
        test_groups;
        test_relative;
        stop_test;
    end
endmodule : operand_addressing_decoder_tb
